// ==== hw/gcs_pkg.sv ====
package gcs_pkg;
    // Register addresses, as carried in the 7-bit address of a serial access
    localparam logic [6:0] ADDR_CONFIG  = 7'h00;
    localparam logic [6:0] ADDR_STATUS  = 7'h01;
    localparam logic [6:0] ADDR_WRCOUNT = 7'h02;
    localparam logic [6:0] ADDR_NODE    = 7'h03;
    localparam logic [6:0] ADDR_PINS    = 7'h04;
    localparam logic [6:0] ADDR_COMPARE = 7'h05;

    // Global configuration field positions
    localparam int CFG_DIAG_A_PP   = 12;
    localparam int CFG_DIAG_B_PP   = 13;
    localparam int CFG_SMALL_HYST  = 14;
    localparam int CFG_STOP_EN     = 15;
    localparam int CFG_DIRECT      = 16;
    localparam int CFG_TEST        = 17;
    localparam int CFG_LOW_IMPL    = 12;
    localparam int CFG_WIDTH       = 18;
    localparam logic [5:0] CFG_RESET = 6'h00;

    // Status field positions
    localparam int ST_RESET = 0;
    localparam int ST_DRV_ERR = 1;
    localparam int ST_PUMP_UV = 2;
    localparam logic [2:0] STATUS_RESET = 3'h1;

    // Node configuration fields
    localparam int NODE_ADDR_LSB  = 0;
    localparam int NODE_DELAY_LSB = 8;
    localparam logic [11:0] NODE_RESET = 12'h000;
    localparam logic [7:0] NODE_ADDR_MAX = 8'hfd;
    localparam logic [6:0] DELAY_RESET = 7'h08;

    // Pin state layout
    localparam int PIN_COUNT   = 8;
    localparam int PIN_EXT_STEP = 6;
    localparam int PIN_COMP     = 7;
    localparam int VERSION_LSB  = 24;
    localparam logic [7:0] VERSION_DEFAULT = 8'h2a;

    // Synchronised inputs: 8 pins, overtemp, short, pump undervoltage, next address
    localparam int SYNC_OT      = 8;
    localparam int SYNC_SHORT   = 9;
    localparam int SYNC_UV      = 10;
    localparam int SYNC_NEXT    = 11;
    localparam int SYNC_WIDTH   = 12;

    localparam logic [0:0] POLARITY_RESET = 1'h1;

    // Direct coil-current fields
    localparam int COIL_A_LSB = 0;
    localparam int COIL_B_LSB = 16;
    localparam int COIL_WIDTH = 9;
    localparam int CUR_SHIFT  = 5;
endpackage

// ==== hw/general_config_status_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Config bit 12 picks first diagnostic drive
// - Config bit 13 picks second diagnostic drive
// - Hysteresis select: sixteenth or thirty-second
// - Stop enable plus encoder high halts sequencer
// - Direct mode: target gives signed coil currents
// - Direct currents scaled; velocity regulation off
// - Reset flag set after reset, read clears
// - Driver error sticky; clears only when gone
// - Pump undervoltage flagged; power stage held off
// - Counter counts good UART writes only
// - Node address, plus one with next-address while base is at most fd
// - Pin register reads live input levels
// - Bit six shows external step source
// - Bit seven shows diagnostic comparator
// - Top byte holds fixed version code
// - Polarity bit sets serial out in UART
// - Polarity bit resets to one
// - Position pulse high while positions equal
// - Global configuration read-write at zero
module general_config_status_regs #(
    parameter logic [7:0] VERSION_CODE = gcs_pkg::VERSION_DEFAULT // Arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [6:0]  regAddr,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [31:0] regWdata,
    output logic      [31:0] regRdata,
    input  wire logic        uartMode,
    input  wire logic        uartWriteOk,
    input  wire logic [7:0]  inputPins,
    input  wire logic        overTemp,
    input  wire logic        shortCircuit,
    input  wire logic        pumpUndervoltage,
    input  wire logic        addressIncrementIn,
    input  wire logic        diagAEvent,
    input  wire logic [31:0] actualPosition,
    input  wire logic [31:0] targetPosition,
    input  wire logic [4:0]  standstillCurrent,
    output logic             diagAPinOut,
    output logic             diagAPinOen,
    output logic             diagBPinOut,
    output logic             diagBPinOen,
    output logic             hystThirtySecond,
    output logic             sequencerHalt,
    output logic             directMode,
    output logic             velocityRegOff,
    output logic [8:0]       coilACurrent,
    output logic [8:0]       coilBCurrent,
    output logic             testOutEnable,
    output logic [1:0]       testSelect,
    output logic             powerStageEnable,
    output logic [7:0]       uartNodeAddress,
    output logic [6:0]       replyDelayBits,
    output logic             serialOutPin,
    output logic             positionPulse
);
    // ****************************************
    // Input synchronisation
    // ****************************************
    // Every pin and fault level is asynchronous, so all pass two flops here
    sync_if syncBus ();

    assign syncBus.raw = {addressIncrementIn, pumpUndervoltage, shortCircuit, overTemp, inputPins};

    pin_sync u_sync (
        .clk  (clk),
        .rstn (rstn),
        .pins (syncBus.sync)
    );

    wire logic [7:0] pinLevels = syncBus.synced[gcs_pkg::PIN_COUNT-1:0];
    wire logic       drvFault  = syncBus.synced[gcs_pkg::SYNC_OT] | syncBus.synced[gcs_pkg::SYNC_SHORT];
    wire logic       pumpLow   = syncBus.synced[gcs_pkg::SYNC_UV];
    wire logic       address_increment_in  = syncBus.synced[gcs_pkg::SYNC_NEXT];
    wire logic       encAHigh  = pinLevels[3];

    // ****************************************
    // Register state
    // ****************************************
    logic [5:0]  configHigh_reg;
    logic [2:0]  status_reg;
    logic [2:0]  status_next;
    logic [7:0]  wrCount_reg;
    logic [11:0] node_reg;
    logic [0:0]  polarity_reg;
    logic [31:0] compare_reg;

    // ****************************************
    // Address decode
    // ****************************************
    wire logic hitConfig  = regAddr == gcs_pkg::ADDR_CONFIG;
    wire logic hitStatus  = regAddr == gcs_pkg::ADDR_STATUS;
    wire logic hitCount   = regAddr == gcs_pkg::ADDR_WRCOUNT;
    wire logic hitPins    = regAddr == gcs_pkg::ADDR_PINS;
    wire logic wrConfig   = regWrite & hitConfig;
    wire logic wrNode     = regWrite & (regAddr == gcs_pkg::ADDR_NODE);
    wire logic wrPolarity = regWrite & hitPins;
    wire logic wrCompare  = regWrite & (regAddr == gcs_pkg::ADDR_COMPARE);
    wire logic rdStatus   = regRead & hitStatus;

    wire logic [31:0] cfgView   = {14'h0000, configHigh_reg, 12'h000};
    wire logic [31:0] statView  = {29'h00000000, status_reg};
    wire logic [31:0] countView = {24'h000000, wrCount_reg};
    wire logic [31:0] pinsView  = {VERSION_CODE, 16'h0000, pinLevels};

    // Write-only registers read as zero
    wire logic [31:0] readMux = hitConfig ? cfgView :
                                hitStatus ? statView :
                                hitCount  ? countView :
                                hitPins   ? pinsView : 32'h00000000;

    // ****************************************
    // Read port
    // ****************************************
    // Data holds until the next read, so a slow host may sample late
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= 32'h00000000;
        end else if (regRead) begin
            regRdata <= readMux;
        end
    end

    // ****************************************
    // Global configuration
    // ****************************************
    // Only bits 17 to 12 are stored; the lower flags belong to other blocks
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            configHigh_reg <= gcs_pkg::CFG_RESET;
        end else if (wrConfig) begin
            configHigh_reg <= regWdata[gcs_pkg::CFG_WIDTH-1:gcs_pkg::CFG_LOW_IMPL];
        end
    end

    wire logic cfgDiagAPp  = configHigh_reg[gcs_pkg::CFG_DIAG_A_PP - gcs_pkg::CFG_LOW_IMPL];
    wire logic cfgDiagBPp  = configHigh_reg[gcs_pkg::CFG_DIAG_B_PP - gcs_pkg::CFG_LOW_IMPL];
    wire logic cfgSmallHys = configHigh_reg[gcs_pkg::CFG_SMALL_HYST - gcs_pkg::CFG_LOW_IMPL];
    wire logic cfgStopEn   = configHigh_reg[gcs_pkg::CFG_STOP_EN - gcs_pkg::CFG_LOW_IMPL];
    wire logic cfgDirect   = configHigh_reg[gcs_pkg::CFG_DIRECT - gcs_pkg::CFG_LOW_IMPL];
    wire logic cfgTest     = configHigh_reg[gcs_pkg::CFG_TEST - gcs_pkg::CFG_LOW_IMPL];

    // ****************************************
    // Global status flags
    // ****************************************
    // Hardware set wins over the read clear in the same cycle
    always_comb begin
        status_next = status_reg;
        if (rdStatus) begin
            status_next[gcs_pkg::ST_RESET] = 1'b0;
            if (!drvFault) begin
                status_next[gcs_pkg::ST_DRV_ERR] = 1'b0;
            end
            status_next[gcs_pkg::ST_PUMP_UV] = 1'b0;
        end
        if (drvFault) begin
            status_next[gcs_pkg::ST_DRV_ERR] = 1'b1;
        end
        if (pumpLow) begin
            status_next[gcs_pkg::ST_PUMP_UV] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status_reg <= gcs_pkg::STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // ****************************************
    // UART write counter
    // ****************************************
    // Wraps at 255; software compares differences
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wrCount_reg <= 8'h00;
        end else if (uartWriteOk && uartMode) begin
            wrCount_reg <= wrCount_reg + 8'h01;
        end
    end

    // ****************************************
    // Node configuration
    // ****************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            node_reg <= gcs_pkg::NODE_RESET;
        end else if (wrNode) begin
            node_reg <= regWdata[11:0];
        end
    end

    wire logic [7:0] nodeBase  = node_reg[gcs_pkg::NODE_DELAY_LSB-1:gcs_pkg::NODE_ADDR_LSB];
    wire logic [3:0] delayCode = node_reg[11:gcs_pkg::NODE_DELAY_LSB];
    // Base above the top legal value is not incremented, so no wrap to zero
    wire logic       canInc    = address_increment_in && (nodeBase <= gcs_pkg::NODE_ADDR_MAX);
    wire logic [7:0] nodeEff   = canInc ? nodeBase + 8'h01 : nodeBase;
    // Odd multiplier from the upper code bits, times eight bit times
    wire logic [6:0] delayEff  = {delayCode[3:1], 1'b1, 3'h0};

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            uartNodeAddress <= 8'h00;
            replyDelayBits  <= gcs_pkg::DELAY_RESET;
        end else begin
            uartNodeAddress <= nodeEff;
            replyDelayBits  <= delayEff;
        end
    end

    // ****************************************
    // Next-address output polarity
    // ****************************************
    // Idles high so a chained node is enabled right after reset
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            polarity_reg <= gcs_pkg::POLARITY_RESET;
        end else if (wrPolarity) begin
            polarity_reg <= regWdata[0:0];
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            serialOutPin <= 1'b1;
        end else begin
            serialOutPin <= uartMode ? polarity_reg[0] : 1'b0;
        end
    end

    // ****************************************
    // Position compare
    // ****************************************
    // Match is registered, as a wide compare would otherwise glitch the pin
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            compare_reg <= 32'h00000000;
        end else if (wrCompare) begin
            compare_reg <= regWdata;
        end
    end

    wire logic posMatch = actualPosition == compare_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            positionPulse <= 1'b0;
        end else begin
            positionPulse <= posMatch;
        end
    end

    // ****************************************
    // Diagnostic pin drive
    // ****************************************
    // Open collector: pull low when active, else release; push-pull drives level
    wire logic diagAOutN = cfgDiagAPp ? diagAEvent : 1'b0;
    wire logic diagAOeN  = cfgDiagAPp ? 1'b0 : ~diagAEvent;
    wire logic diagBOutN = cfgDiagBPp ? posMatch : 1'b0;
    wire logic diagBOeN  = cfgDiagBPp ? 1'b0 : ~posMatch;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            diagAPinOut <= 1'b0;
            diagAPinOen <= 1'b1;
            diagBPinOut <= 1'b0;
            diagBPinOen <= 1'b1;
        end else begin
            diagAPinOut <= diagAOutN;
            diagAPinOen <= diagAOeN;
            diagBPinOut <= diagBOutN;
            diagBPinOen <= diagBOeN;
        end
    end

    // ****************************************
    // Motion and current control outputs
    // ****************************************
    wire logic signed [8:0] coilARaw = targetPosition[gcs_pkg::COIL_A_LSB +: gcs_pkg::COIL_WIDTH];
    wire logic signed [8:0] coilBRaw = targetPosition[gcs_pkg::COIL_B_LSB +: gcs_pkg::COIL_WIDTH];
    wire logic        [5:0] scaleU   = {1'b0, standstillCurrent} + 6'h01;
    wire logic signed [6:0] scale    = {1'b0, scaleU};
    // Nine bits times at most 32 fits the 16-bit product
    // Full-scale standstill setting passes the programmed current unchanged
    wire logic signed [15:0] prodA   = coilARaw * scale;
    wire logic signed [15:0] prodB   = coilBRaw * scale;
    wire logic signed [15:0] shA     = prodA >>> gcs_pkg::CUR_SHIFT;
    wire logic signed [15:0] shB     = prodB >>> gcs_pkg::CUR_SHIFT;
    wire logic        [8:0] coilANx  = cfgDirect ? shA[8:0] : 9'h000;
    wire logic        [8:0] coilBNx  = cfgDirect ? shB[8:0] : 9'h000;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            coilACurrent <= 9'h000;
            coilBCurrent <= 9'h000;
            directMode   <= 1'b0;
            velocityRegOff <= 1'b0;
        end else begin
            coilACurrent <= coilANx;
            coilBCurrent <= coilBNx;
            directMode   <= cfgDirect;
            velocityRegOff <= cfgDirect;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hystThirtySecond <= 1'b0;
            sequencerHalt    <= 1'b0;
            testOutEnable    <= 1'b0;
            testSelect       <= 2'h0;
        end else begin
            hystThirtySecond <= cfgSmallHys;
            sequencerHalt    <= cfgStopEn & encAHigh;
            // Test routing is only passed on; the host keeps it clear
            testOutEnable    <= cfgTest;
            testSelect       <= standstillCurrent[1:0];
        end
    end

    // ****************************************
    // Power stage enable
    // ****************************************
    // Follows the synchronised faults, so it drops three edges late at worst
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            powerStageEnable <= 1'b0;
        end else begin
            powerStageEnable <= ~pumpLow & ~drvFault;
        end
    end
endmodule
`default_nettype wire

// ==== hw/pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    input  wire logic clk,
    input  wire logic rstn,
    sync_if.sync      pins
);
    // ****************************************
    // Two-stage synchronisers
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < gcs_pkg::SYNC_WIDTH; i = i + 1) begin : g_bit
            logic meta;
            logic stable;
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    meta   <= 1'b0;
                    stable <= 1'b0;
                end else begin
                    meta   <= pins.raw[i];
                    stable <= meta;
                end
            end
            assign pins.synced[i] = stable;
        end
    endgenerate
endmodule
`default_nettype wire

// ==== hw/sync_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface sync_if;
    logic [gcs_pkg::SYNC_WIDTH-1:0] raw;
    logic [gcs_pkg::SYNC_WIDTH-1:0] synced;
    modport sync (input raw, output synced);
    modport user (output raw, input synced);
endinterface
`default_nettype wire

// ==== verification/gcs_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// Register checker
// ****************
module gcs_checker (
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic [6:0]  regAddr,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [31:0] regWdata,
    input wire logic [31:0] regRdata,
    input wire logic [7:0]  inputPins,
    input wire logic        pumpUndervoltage,
    input wire logic        diagAEvent,
    input wire logic [31:0] actualPosition,
    input wire logic        diagAPinOut,
    input wire logic        diagAPinOen,
    input wire logic        diagBPinOen,
    input wire logic        hystThirtySecond,
    input wire logic        sequencerHalt,
    input wire logic        directMode,
    input wire logic        testOutEnable,
    input wire logic        powerStageEnable,
    input wire logic        positionPulse
);
    logic [5:0]  cfgReg;
    logic [31:0] cmpReg;
    logic        matchReg;
    wire         cfgWr = regWrite && regAddr == 7'h00;
    wire         cmpWr = regWrite && regAddr == 7'h05;
    // Shadows of the config and compare registers, so outputs tie back to bus writes
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfgReg   <= 6'h00;
            cmpReg   <= 32'h0;
            matchReg <= 1'b0;
        end else begin
            if (cfgWr) cfgReg <= regWdata[17:12];
            if (cmpWr) cmpReg <= regWdata;
            matchReg <= cmpReg == actualPosition;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    a_pulse_match: assert property (positionPulse == matchReg)
        else $error("position pulse disagrees with compare");
    a_cfg_readback: assert property (regRead && regAddr == 7'h00 |=> regRdata[11:0] == 12'h000 &&
        regRdata[31:18] == 14'h0000 && regRdata[17:12] == $past(cfgReg)) else $error("config readback wrong");
    a_wo_reads_zero: assert property (regRead && (regAddr == 7'h03 || regAddr >= 7'h05) |=> regRdata == 32'h0)
        else $error("write-only or unmapped read not zero");
    a_reset_once: assert property (regRead && regAddr == 7'h01 ##[1:40] regRead && regAddr == 7'h01
        |=> !regRdata[0]) else $error("reset flag survived a read");
    a_uv_power_off: assert property (pumpUndervoltage [*4] |=> !powerStageEnable)
        else $error("power stage on during undervoltage");
    a_halt_cause: assert property (sequencerHalt |-> $past(inputPins[3], 3) && $past(cfgReg[3]))
        else $error("halt without stop enable and encoder");
    a_diag_a_push: assert property ($past(rstn) && $past(cfgReg[0]) |->
        !diagAPinOen && diagAPinOut == $past(diagAEvent)) else $error("diag A push-pull wrong");
    a_diag_a_open: assert property ($past(rstn) && !$past(cfgReg[0]) |->
        !diagAPinOut && diagAPinOen == !$past(diagAEvent)) else $error("diag A open collector wrong");
    a_diag_b_push: assert property ($past(cfgReg[1]) |-> !diagBPinOen)
        else $error("diag B push-pull released");
    a_cfg_outputs: assert property ($past(rstn) |-> {testOutEnable, directMode, hystThirtySecond} ==
        {$past(cfgReg[5]), $past(cfgReg[4]), $past(cfgReg[2])}) else $error("config outputs wrong");
    c_pulse: cover property (positionPulse);
    c_halt: cover property (sequencerHalt);
    c_power_off: cover property (!powerStageEnable);
endmodule
bind general_config_status_regs gcs_checker u_gcs_checker (.clk, .rstn, .regAddr, .regWrite, .regRead, .regWdata,
    .regRdata, .inputPins, .pumpUndervoltage, .diagAEvent, .actualPosition, .diagAPinOut, .diagAPinOen,
    .diagBPinOen, .hystThirtySecond, .sequencerHalt, .directMode, .testOutEnable, .powerStageEnable, .positionPulse);
`default_nettype wire

// ==== verification/host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************
// Host side of the register bus
// ****************
module host_model (
    input  wire logic        clk,
    output logic      [6:0]  regAddr,
    output logic             regWrite,
    output logic             regRead,
    output logic      [31:0] regWdata,
    input  wire logic [31:0] regRdata
);
    initial begin
        regAddr  = 7'h7f;
        regWrite = 1'b0;
        regRead  = 1'b0;
        regWdata = 32'h0;
    end
    // Released lines flip, so a stale value never looks valid
    task automatic writeReg(input logic [6:0] a, input logic [31:0] d);
        @(posedge clk);
        #1;
        regAddr  = a;
        regWdata = d;
        regWrite = 1'b1;
        @(posedge clk);
        #1;
        regWrite = 1'b0;
        regAddr  = ~a;
        regWdata = ~d;
    endtask
    task automatic readReg(input logic [6:0] a, output logic [31:0] d);
        @(posedge clk);
        #1;
        regAddr = a;
        regRead = 1'b1;
        @(posedge clk);
        #1;
        regRead = 1'b0;
        regAddr = ~a;
        d       = regRdata;
    endtask
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checkCount++; if ((a) !== (b)) begin errors++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module tb;
    localparam logic [7:0] VERSION = 8'h5c; // Arbitrary value
    logic        clk, rstn, regWrite, regRead, uartMode, uartWriteOk, overTemp, shortCircuit;
    logic        pumpUndervoltage, addressIncrementIn, diagAEvent, diagAPinOut, diagAPinOen;
    logic        diagBPinOut, diagBPinOen, hystThirtySecond, sequencerHalt, directMode, velocityRegOff;
    logic        testOutEnable, powerStageEnable, serialOutPin, positionPulse;
    logic [6:0]  regAddr, replyDelayBits;
    logic [7:0]  inputPins, uartNodeAddress;
    logic [4:0]  standstillCurrent;
    logic [1:0]  testSelect;
    logic [8:0]  coilACurrent, coilBCurrent;
    logic [31:0] regWdata, regRdata, actualPosition, targetPosition, rd;
    int          errors, checkCount;
    general_config_status_regs #(.VERSION_CODE(VERSION)) u_general_config_status_regs (.clk, .rstn, .regAddr,
        .regWrite, .regRead, .regWdata, .regRdata, .uartMode, .uartWriteOk, .inputPins, .overTemp, .shortCircuit,
        .pumpUndervoltage, .addressIncrementIn, .diagAEvent, .actualPosition, .targetPosition, .standstillCurrent,
        .diagAPinOut, .diagAPinOen, .diagBPinOut, .diagBPinOen, .hystThirtySecond, .sequencerHalt, .directMode,
        .velocityRegOff, .coilACurrent, .coilBCurrent, .testOutEnable, .testSelect, .powerStageEnable,
        .uartNodeAddress, .replyDelayBits, .serialOutPin, .positionPulse);
    host_model u_host_model (.clk, .regAddr, .regWrite, .regRead, .regWdata, .regRdata);
    // ****************
    // Bus helpers
    // ****************
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        u_host_model.writeReg(a, d);
    endtask
    task automatic rdChk(input logic [6:0] a, input logic [31:0] e);
        u_host_model.readReg(a, rd);
        `CHK(rd, e)
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic summarize;
        $display("Counts: %0d checks, %0d errors", checkCount, errors);
        if (errors == 0 && checkCount > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Hang guard, well past the longest sequence
    initial begin
        #1000000;
        errors++;
        summarize();
    end
    // ****************
    // Tests
    // ****************
    initial begin
        {uartWriteOk, overTemp, shortCircuit, pumpUndervoltage, addressIncrementIn, inputPins} = '0;
        {actualPosition, targetPosition} = '0;
        {rstn, uartMode, diagAEvent, standstillCurrent} = 8'h7f;
        cyc(6);
        rstn = 1'b1;
        cyc(2);
        `CHK({serialOutPin, replyDelayBits, uartNodeAddress}, {1'b1, 7'h08, 8'h00})
        rdChk(7'h01, 32'h1);
        rdChk(7'h01, 32'h0);
        rdChk(7'h00, 32'h0);
        $display("reset test done");
        standstillCurrent = 5'h0f;
        for (int i = 12; i < 18; i++) begin
            wr(7'h00, (32'h1 << i) | 32'hfffc0fff);
            rdChk(7'h00, 32'h1 << i);
            `CHK({testOutEnable, directMode}, {i == 17, i == 16})
            `CHK({velocityRegOff, hystThirtySecond}, {i == 16, i == 14})
            `CHK({diagAPinOut, diagAPinOen, diagBPinOut, diagBPinOen}, {i == 12, 1'b0, i == 13, 1'b0})
        end
        `CHK(testSelect, 2'h3)
        wr(7'h00, 32'h10000);
        targetPosition = 32'h01f00040;
        cyc(3);
        `CHK({coilBCurrent, coilACurrent}, {9'h1f8, 9'h020})
        standstillCurrent = 5'h1f;
        cyc(2);
        `CHK({coilBCurrent, coilACurrent}, {9'h1f0, 9'h040})
        diagAEvent = 1'b0;
        wr(7'h00, 32'h8000);
        inputPins = 8'h08;
        cyc(4);
        `CHK({sequencerHalt, coilACurrent}, {1'b1, 9'h000})
        wr(7'h00, 32'h0);
        cyc(1);
        `CHK(sequencerHalt, 1'b0)
        $display("config test done");
        {overTemp, pumpUndervoltage} = 2'b11;
        cyc(4);
        `CHK(powerStageEnable, 1'b0)
        rdChk(7'h01, 32'h6);
        rdChk(7'h01, 32'h6);
        {overTemp, pumpUndervoltage} = 2'b00;
        cyc(4);
        `CHK(powerStageEnable, 1'b1)
        rdChk(7'h01, 32'h6);
        rdChk(7'h01, 32'h0);
        shortCircuit = 1'b1;
        cyc(4);
        shortCircuit = 1'b0;
        cyc(4);
        rdChk(7'h01, 32'h2);
        wr(7'h01, 32'h7);
        rdChk(7'h01, 32'h0);
        $display("status test done");
        for (int k = 0; k < 3; k++) begin
            uartWriteOk = 1'b1;
            cyc(1);
            uartWriteOk = 1'b0;
            rdChk(7'h02, 32'(k + 1));
        end
        wr(7'h02, 32'hff);
        rdChk(7'h02, 32'h3);
        $display("counter test done");
        // Lone node on the bus, so the shortest delay is legal
        for (int c = 0; c < 16; c++) begin
            wr(7'h03, {20'h0, 4'(c), 8'h05});
            cyc(1);
            `CHK({replyDelayBits, uartNodeAddress}, {7'((c / 2 * 2 + 1) * 8), 8'h05})
        end
        addressIncrementIn = 1'b1;
        cyc(4);
        `CHK(uartNodeAddress, 8'h06)
        wr(7'h03, 32'h0fd);
        cyc(1);
        `CHK(uartNodeAddress, 8'hfe)
        wr(7'h03, 32'h0fe);
        cyc(1);
        `CHK(uartNodeAddress, 8'hfe)
        rdChk(7'h03, 32'h0);
        $display("node test done");
        inputPins = 8'hc9;
        wr(7'h04, 32'hfffffffe);
        cyc(1);
        `CHK(serialOutPin, 1'b0)
        rdChk(7'h04, {VERSION, 16'h0, 8'hc9});
        wr(7'h04, 32'h1);
        cyc(1);
        `CHK(serialOutPin, 1'b1)
        uartMode = 1'b0;
        cyc(2);
        `CHK(serialOutPin, 1'b0)
        $display("pin test done");
        actualPosition = 32'h80001234;
        wr(7'h05, 32'h80001234);
        cyc(1);
        `CHK(positionPulse, 1'b1)
        actualPosition = 32'h80001235;
        cyc(1);
        `CHK(positionPulse, 1'b0)
        rdChk(7'h05, 32'h0);
        rdChk(7'h06, 32'h0);
        $display("compare test done");
        wr(7'h00, 32'h20000);
        rstn = 1'b0;
        cyc(2);
        rstn = 1'b1;
        cyc(2);
        rdChk(7'h01, 32'h1);
        rdChk(7'h00, 32'h0);
        $display("second reset test done");
        summarize();
    end
endmodule
`default_nettype wire
